//--- tec_pkg.sv
package tec_pkg;

  // Register byte addresses on the APB side
  localparam logic [7:0] TEC_ADDR_COUNT_HIGH = 8'h00;
  localparam logic [7:0] TEC_ADDR_COUNT_LOW = 8'h04;
  localparam logic [7:0] TEC_ADDR_CONTROL = 8'h08;
  localparam logic [7:0] TEC_ADDR_INTCTL = 8'h0C;

  // Control register field positions
  localparam int TEC_EDGE_BIT = 3;
  localparam int TEC_RUN_BIT = 4;
  localparam int TEC_OPLO_BIT = 6;
  localparam int TEC_OPHI_BIT = 7;
  localparam logic [7:0] TEC_CTRL_MASK = 8'hD8;
  localparam logic [7:0] TEC_CTRL_RESET = 8'h00;

  // Interrupt control register field positions
  localparam int TEC_IRQ_EN_BIT = 0;
  localparam int TEC_IRQ_FLAG_BIT = 6;

  localparam logic [15:0] TEC_COUNT_RESET = 16'h0000;
  localparam logic [15:0] TEC_COUNT_MAX = 16'hFFFF;
  localparam logic [7:0] TEC_BYTE_RESET = 8'h00;

  // Internal count clock divider (instruction clock from sys_clk)
  localparam int TEC_INSTR_DIV = 4;

  typedef enum logic [1:0] {
    TEC_MODE_UNUSED = 2'b00,
    TEC_MODE_EVENT = 2'b01,
    TEC_MODE_TIMER = 2'b10,
    TEC_MODE_PULSE = 2'b11
  } tec_mode_t;

  typedef struct packed {
    logic [15:0] addr;
    logic write;
    logic [31:0] wdata;
  } tec_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } tec_rsp_t;

endpackage

//--- tec_sync.sv
`timescale 1ns/10ps
module tec_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Data
  input wire logic din,
  output logic dout
);
  logic stage1;
  logic stage2;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
    end
  end

  assign dout = stage2;
endmodule // tec_sync

//--- tec_tick.sv
`timescale 1ns/10ps
module tec_tick #(
  parameter int DIV = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Tick out, one cycle every DIV cycles
  output logic tick
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_tick;

  if (DIV < 1) begin : g_bad_div
    $error("tec_tick: DIV must be at least 1");
  end

  always_comb begin
    next_tick = (cnt == W'(DIV - 1));
    next_cnt = next_tick ? '0 : cnt + W'(1);
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule // tec_tick

//--- tec_timer.sv
`timescale 1ns/10ps
// What this block does
// - Pulse mode with run set starts counting on the selected edge only.
// - Pulse mode stops when input returns to prior level; hardware clears run.
// - After one measurement the count holds; later edges are ignored.
// - Setting run again re-arms the measurement for the next edge.
// - Measurement starts on an edge, never on an already active level.
// - Overflow in pulse mode reloads and raises the flag as other modes.
// - Counting only happens while run bit 4 is one.
// - Hardware clears run only in pulse mode; otherwise software only.
// - Overflow is offered as a wake-up event.
// - Interrupt enable at zero keeps the interrupt request low.
// - Preload write with run clear also loads the counter.
// - Preload write with run set changes only preload; reload at overflow.
// - Reading the high count register blocks the count clock that cycle.
// - Edge select 0 means rising, 1 means falling, in pulse mode only; event mode counts rising edges.
// - Mode 01 event, 10 timer, 11 pulse width, 00 unused.
// - Control bits 0 to 2 and 5 read as zero.
// - Counter counts up to FFFF, then reloads and sets flag bit 6.
// - Event mode counts rising pin edges; timer and pulse modes count instruction ticks.
// - Low write fills a byte buffer; high write loads both bytes to preload.
// - High read returns upper byte and latches lower byte into buffer.
module tec_timer #(
  parameter int INSTR_DIV = tec_pkg::TEC_INSTR_DIV
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External count pin
  input wire logic external_count_input,
  // Events
  output logic irq,
  output logic wake_up
);
  import tec_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input conditioning
  logic pin_sync;
  logic pin_prev;
  logic instr_tick;

  tec_sync u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .din(external_count_input),
    .dout(pin_sync)
  );

  tec_tick #(.DIV(INSTR_DIV)) u_tick (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .tick(instr_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State
  tec_req_t req;
  logic [7:0] ctrl;
  logic [15:0] count;
  logic [15:0] preload;
  logic [7:0] low_buf;
  logic irq_en;
  logic irq_flag;
  logic measuring;
  logic done;
  logic [31:0] rd_q;
  logic rdy_q;
  logic irq_q;
  logic wake_q;

  logic [7:0] next_ctrl;
  logic [15:0] next_count;
  logic [15:0] next_preload;
  logic [7:0] next_low_buf;
  logic next_irq_en;
  logic next_irq_flag;
  logic next_measuring;
  logic next_done;
  logic [31:0] next_rd_q;
  logic next_rdy_q;
  logic next_irq_q;
  logic next_wake_q;

  logic access;
  logic wr;
  logic rd;
  logic run;
  logic edge_sel;
  tec_mode_t mode;
  logic rise;
  logic fall;
  logic trig;
  logic untrig;
  logic inc;
  logic ovf;
  logic hold_clk;

  assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
  assign run = ctrl[TEC_RUN_BIT];
  assign edge_sel = ctrl[TEC_EDGE_BIT];
  assign mode = tec_mode_t'({ctrl[TEC_OPHI_BIT], ctrl[TEC_OPLO_BIT]});

  // One wait state: read data is captured in the first access cycle and shown with pready;
  // a write lands only at the edge where pready is seen high, so a master never sees it early
  assign access = psel && penable && !rdy_q;
  assign wr = psel && penable && rdy_q && req.write;
  assign rd = access && !req.write;

  assign rise = pin_sync && !pin_prev;
  assign fall = !pin_sync && pin_prev;
  assign trig = edge_sel ? fall : rise;
  assign untrig = edge_sel ? rise : fall;
  assign hold_clk = rd && (req.addr[7:0] == TEC_ADDR_COUNT_HIGH);

  ////////////////////////////////////////////////////////////////////////////
  // Count source selection
  always_comb begin
    inc = 1'b0;
    unique case (mode)
      TEC_MODE_EVENT: inc = rise;
      TEC_MODE_TIMER: inc = instr_tick;
      TEC_MODE_PULSE: inc = instr_tick && measuring;
      TEC_MODE_UNUSED: inc = 1'b0;
    endcase
    inc = inc && run && !hold_clk;
  end

  assign ovf = inc && (count == TEC_COUNT_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_ctrl = ctrl;
    next_count = count;
    next_preload = preload;
    next_low_buf = low_buf;
    next_irq_en = irq_en;
    next_irq_flag = irq_flag;
    next_measuring = measuring;
    next_done = done;
    next_rd_q = 32'h00000000;
    next_rdy_q = access;
    next_irq_q = 1'b0;
    next_wake_q = 1'b0;

    // Counting and overflow reload
    if (inc) begin
      next_count = ovf ? preload : count + 16'h0001;
    end

    // Pulse-width sequencing; edges only, never the level
    if (mode == TEC_MODE_PULSE && run) begin
      if (!measuring && !done && trig) begin
        next_measuring = 1'b1;
      end else if (measuring && untrig) begin
        next_measuring = 1'b0;
        next_done = 1'b1;
        next_ctrl[TEC_RUN_BIT] = 1'b0;
      end
    end else begin
      next_measuring = 1'b0;
    end

    // Register writes
    if (wr) begin
      unique case (req.addr[7:0])
        TEC_ADDR_COUNT_LOW: next_low_buf = req.wdata[7:0];
        TEC_ADDR_COUNT_HIGH: begin
          next_preload = {req.wdata[7:0], low_buf};
          if (!run) begin
            next_count = {req.wdata[7:0], low_buf};
          end
          // With run set only the preload changes
        end
        TEC_ADDR_CONTROL: begin
          next_ctrl = req.wdata[7:0] & TEC_CTRL_MASK;
          if (req.wdata[TEC_RUN_BIT]) begin
            next_done = 1'b0;
          end
        end
        TEC_ADDR_INTCTL: begin
          next_irq_en = req.wdata[TEC_IRQ_EN_BIT];
          if (!req.wdata[TEC_IRQ_FLAG_BIT]) begin
            next_irq_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Set wins over a simultaneous software clear
    if (ovf) begin
      next_irq_flag = 1'b1;
    end

    // Register reads
    if (rd) begin
      unique case (req.addr[7:0])
        TEC_ADDR_COUNT_HIGH: begin
          next_rd_q = {24'h000000, count[15:8]};
          next_low_buf = count[7:0];
        end
        TEC_ADDR_COUNT_LOW: next_rd_q = {24'h000000, low_buf};
        TEC_ADDR_CONTROL: next_rd_q = {24'h000000, ctrl & TEC_CTRL_MASK};
        TEC_ADDR_INTCTL: begin
          next_rd_q[TEC_IRQ_EN_BIT] = irq_en;
          next_rd_q[TEC_IRQ_FLAG_BIT] = irq_flag;
        end
        default: next_rd_q = 32'h00000000;
      endcase
    end

    next_irq_q = next_irq_flag && next_irq_en;
    next_wake_q = ovf;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= TEC_CTRL_RESET;
      count <= TEC_COUNT_RESET;
      preload <= TEC_COUNT_RESET;
      low_buf <= TEC_BYTE_RESET;
      irq_en <= 1'b0;
      irq_flag <= 1'b0;
      measuring <= 1'b0;
      done <= 1'b0;
      rd_q <= 32'h00000000;
      rdy_q <= 1'b0;
      irq_q <= 1'b0;
      wake_q <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      count <= next_count;
      preload <= next_preload;
      low_buf <= next_low_buf;
      irq_en <= next_irq_en;
      irq_flag <= next_irq_flag;
      measuring <= next_measuring;
      done <= next_done;
      rd_q <= next_rd_q;
      rdy_q <= next_rdy_q;
      irq_q <= next_irq_q;
      wake_q <= next_wake_q;
      pin_prev <= pin_sync;
    end
  end

  assign prdata = rd_q;
  assign pready = rdy_q;
  assign pslverr = 1'b0;
  assign irq = irq_q;
  assign wake_up = wake_q;
endmodule // tec_timer

//--- tec_timer_props.sv
`timescale 1ns/10ps
module tec_timer_props #(
  parameter int INSTR_DIV = tec_pkg::TEC_INSTR_DIV
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pin and events
  input wire logic external_count_input,
  input wire logic irq,
  input wire logic wake_up
);
  import tec_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic ictl;
  assign ictl = psel && pwrite && paddr[7:0] == TEC_ADDR_INTCTL;
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no ready");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready too long");
  a_ready_has_access: assert property ($rose(pready) |-> $past(psel && penable))
    else $error("ready without access");
  a_ctrl_unused_zero: assert property (pready && !pwrite && paddr[7:0] == TEC_ADDR_CONTROL
    |-> prdata[2:0] == 3'h0 && !prdata[5]) else $error("unused bits set");
  a_irq_masked: assert property (ictl && penable && !pready && !pwdata[0] |-> ##2 !irq)
    else $error("irq while masked");
  a_irq_holds: assert property (irq && !ictl |=> irq)
    else $error("irq dropped");
  a_irq_has_cause: assert property ($rose(irq) |-> wake_up || $past(wake_up) || $past(wake_up, 2)
    || $past(ictl) || $past(ictl, 2)) else $error("irq without cause");
  a_wake_single: assert property (wake_up |=> !wake_up)
    else $error("wake too long");
endmodule // tec_timer_props

bind tec_timer tec_timer_props #(.INSTR_DIV(INSTR_DIV)) tec_timer_props_i (.sys_clk(sys_clk), .resetn(resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .external_count_input(external_count_input), .irq(irq),
  .wake_up(wake_up));

//--- tec_pulse_src.sv
`timescale 1ns/10ps
module tec_pulse_src (
  // Clock
  input wire logic sys_clk,
  // Pin toward the timer
  output logic pin
);
  initial pin = 1'b0;
  task automatic set_level(input logic lvl);
    @(posedge sys_clk);
    pin <= lvl;
  endtask
  // Width sets a prompt or a slow source; the pin always returns to idle
  task automatic pulse(input logic lvl, input int width, input int gap);
    @(posedge sys_clk);
    pin <= lvl;
    repeat (width) @(posedge sys_clk);
    pin <= !lvl;
    repeat (gap) @(posedge sys_clk);
  endtask
endmodule // tec_pulse_src

//--- tec_timer_tb_top.sv
`timescale 1ns/10ps
module tec_timer_tb_top;
  import tec_pkg::*;
  logic sys_clk, resetn, psel, penable, pwrite, pin, pready, pslverr, irq, wake_up;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed, cnt, pre;
  int num_errors = 0, num_checks = 0, n, k;
  tec_timer tec_timer_i (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_count_input(pin), .irq(irq), .wake_up(wake_up));
  tec_pulse_src tec_pulse_src_i (.sys_clk(sys_clk), .pin(pin));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  //////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic report_and_stop;
    if (num_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol = 0);
    num_checks++;
    if ((^got) === 1'bx || got + tol < exp || got > exp + tol) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {8'h00, a};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge sys_clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t == 50) num_errors++;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Low byte goes to the buffer first, so both bytes land together
  task automatic load(input logic [15:0] v);
    apb(1'b1, TEC_ADDR_COUNT_LOW, {24'h0, v[7:0]});
    apb(1'b1, TEC_ADDR_COUNT_HIGH, {24'h0, v[15:8]});
  endtask
  task automatic rcount;
    apb(1'b0, TEC_ADDR_COUNT_HIGH, 32'h0);
    cnt = {16'h0, rd[7:0], 8'h00};
    apb(1'b0, TEC_ADDR_COUNT_LOW, 32'h0);
    cnt[7:0] = rd[7:0];
  endtask
  //////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    report_and_stop;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    seed = 32'h8D05;
    resetn = 1'b0;
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    rchk(TEC_ADDR_CONTROL, 32'h0);
    rchk(8'h10, 32'h0);
    for (k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      apb(1'b1, TEC_ADDR_CONTROL, {24'h0, k[1:0], seed[5:0] & 6'h2F});
      rchk(TEC_ADDR_CONTROL, {24'h0, k[1:0], seed[5:0] & 6'h08});
    end
    pre = {17'h0, seed[14:0]};
    load(pre[15:0]);
    rcount;
    chk(cnt, pre);
    n = seed[2:0] + 1;
    apb(1'b1, TEC_ADDR_CONTROL, 32'h50);
    repeat (n) tec_pulse_src_i.pulse(1'b1, 3, 3);
    apb(1'b1, TEC_ADDR_CONTROL, 32'h40);
    rcount;
    chk(cnt, pre + n);
    load(16'hFFF8);
    apb(1'b1, TEC_ADDR_INTCTL, 32'h01);
    apb(1'b1, TEC_ADDR_CONTROL, 32'h90);
    load(16'h1234);
    n = 0;
    while (wake_up !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    chk(32'(wake_up), 32'h1);
    repeat (2) @(posedge sys_clk);
    chk(32'(irq), 32'h1);
    rchk(TEC_ADDR_CONTROL, 32'h90);
    rchk(TEC_ADDR_INTCTL, 32'h41);
    apb(1'b1, TEC_ADDR_INTCTL, 32'h40);
    rchk(TEC_ADDR_INTCTL, 32'h40);
    chk(32'(irq), 32'h0);
    apb(1'b1, TEC_ADDR_CONTROL, 32'h0);
    rcount;
    chk(cnt, 32'h123A, 6);
    apb(1'b1, TEC_ADDR_INTCTL, 32'h0);
    rchk(TEC_ADDR_INTCTL, 32'h0);
    // Armed while already at the active level: only a real edge may start it
    for (k = 0; k < 2; k++) begin
      apb(1'b1, TEC_ADDR_CONTROL, 32'h0);
      load(16'h0000);
      tec_pulse_src_i.set_level(k == 0);
      apb(1'b1, TEC_ADDR_CONTROL, {24'h0, 4'hD, k[0], 3'h0});
      repeat (20) @(posedge sys_clk);
      rcount;
      chk(cnt, 32'h0);
      tec_pulse_src_i.pulse(k != 0, 4, 4);
      tec_pulse_src_i.pulse(k == 0, 40, 8);
      rchk(TEC_ADDR_CONTROL, {24'h0, 4'hC, k[0], 3'h0});
      // Active level lasts 45 clocks, so 11 or 12 instruction ticks
      rcount;
      chk(cnt, 32'd11, 1);
      tec_pulse_src_i.pulse(k == 0, 40, 8);
      rcount;
      chk(cnt, 32'd11, 1);
      apb(1'b1, TEC_ADDR_CONTROL, {24'h0, 4'hD, k[0], 3'h0});
      tec_pulse_src_i.pulse(k == 0, 40, 8);
      rcount;
      chk(cnt, 32'd21, 1);
    end
    report_and_stop;
  end
endmodule // tec_timer_tb_top
